// file: logic/rmii_rx_path_config_pkg.sv
// constants for the MAC interface control/status block
// assumes a 32-bit classic Wishbone bus and word-indexed register addresses
//
// Function
// - Bit 8 set enables the internal transmit clock shift, cleared disables it, reset is zero.
// - Bit 7 selects a 50 MHz oscillator reference when one and 25 MHz when zero.
// - Bit 7 takes its power-up value from the reference frequency strap and may be rewritten.
// - In recovered-clock reduced mode, bit 6 cleared bypasses the receive FIFO; reset is one.
// - While the FIFO is bypassed the receive clock output carries the reference clock.
// - Bit 5 selects reduced mode when one and full MII when zero, reset zero.
// - Revision bit one holds CRS_DV high until the last receive data has left.
// - Revision bit zero toggles CRS_DV after carrier loss while data still drains.
// - A receive buffer overflow sets a read-only flag that a register read clears.
// - A receive buffer underflow sets a read-only flag that a register read clears.
// - Size code 00 gives 14 bits, 01 gives 2 bits, 10 gives 6 bits of tolerance.
// - The elasticity buffer absorbs offset between the interface clock and line data.
// - The size field resets to 01 and software may write it.
// - With the reduced-gigabit enable bit clear, the mode follows bit 5.
package rmii_rx_path_config_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] CTL_IDX = 6'h17;
   localparam logic [5:0] IRQ_ST_IDX = 6'h18;
   localparam logic [5:0] IRQ_MASK_IDX = 6'h19;
   localparam int ADR_LSB = 2;
   localparam int ADR_W = 8;

   // field positions in the control/status register
   localparam int RGMII_EN_BIT = 9;
   localparam int TX_SHIFT_BIT = 8;
   localparam int REF_SEL_BIT = 7;
   localparam int FIFO_NORM_BIT = 6;
   localparam int RMII_SEL_BIT = 5;
   localparam int REV10_BIT = 4;
   localparam int OVF_BIT = 3;
   localparam int UNF_BIT = 2;
   localparam int EBUF_LSB = 0;
   localparam int LANE_W = 8;

   // interrupt status/mask layout
   localparam int IRQ_OVF_BIT = 1;
   localparam int IRQ_UNF_BIT = 0;

   // reset values
   localparam logic FIFO_NORM_RST = 1'b1;
   localparam logic [1:0] EBUF_RST = 2'h1;

   // elasticity buffer: tolerance in dibits to pre-fill before release
   localparam int BUF_AW = 4;
   localparam logic [4:0] BUF_DEPTH = 5'h10;
   localparam logic [4:0] FILL_14BIT = 5'h07;
   localparam logic [4:0] FILL_2BIT = 5'h01;
   localparam logic [4:0] FILL_6BIT = 5'h03;
   localparam logic [1:0] EBUF_14 = 2'h0;
   localparam logic [1:0] EBUF_2 = 2'h1;
   localparam logic [1:0] EBUF_6 = 2'h2;

   // strap pin synchroniser settles after this many cycles
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage : rmii_rx_path_config_pkg

// file: logic/rmii_rx_path_config.sv
// control/status register and receive elasticity buffer of the MAC interface
// assumes line data arrives as dibit pulses on clk_i and the reference clock is slow
// enough to be sampled by clk_i
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rmii_rx_path_config (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [rmii_rx_path_config_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ref_clk_i,
   input wire logic ref_freq_strap_pin_i,
   input wire logic line_dv_i,
   input wire logic line_valid_i,
   input wire logic [1:0] line_d_i,
   output logic [1:0] rxd_o,
   output logic crs_dv_o,
   output logic rx_clk_o,
   output logic tx_clk_shift_o,
   output logic ref_sel_o,
   output logic rmii_mode_o,
   output logic irq_o
);
   import rmii_rx_path_config_pkg::*;

   typedef struct packed {
      logic ref_s1;
      logic ref_s2;
      logic ref_s3;
      logic strap_s1;
      logic strap_s2;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic rgmii_en;
      logic tx_shift;
      logic ref_sel;
      logic fifo_norm;
      logic rmii_sel;
      logic rev10;
      logic ovf;
      logic unf;
      logic [1:0] ebuf_sz;
      logic [1:0] irq_st;
      logic [1:0] irq_mask;
      logic irq;
      logic ack;
      logic [31:0] dat;
      logic [(1<<BUF_AW)-1:0][1:0] mem;
      logic [BUF_AW-1:0] wr_ptr;
      logic [BUF_AW-1:0] rd_ptr;
      logic [4:0] cnt;
      logic started;
      logic tgl;
      logic [1:0] byp_d;
      logic [1:0] rxd;
      logic crs_dv;
      logic rx_clk;
      logic rmii_mode;
   } state_t;

   state_t q, d;
   logic [5:0] idx;
   logic bus_req, wr_ack, rd_ack;
   logic link_edge, bypass, push, pop, ovf_ev, unf_ev;
   logic [4:0] fill_need;
   logic [15:0] ctl_rd;

   assign idx = wb_adr_i[ADR_LSB +: 6];
   assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
   assign wr_ack = bus_req && wb_we_i;
   assign rd_ack = bus_req && !wb_we_i;
   assign link_edge = q.ref_s2 && !q.ref_s3;

   ////////////////////////////////////////////////////////////////////////////
   // bypass only in reduced mode with the normal bit cleared
   assign bypass = q.rmii_mode && !q.fifo_norm;

   // pre-fill depth per size code; the reserved code acts as the smallest
   always_comb begin
      unique case (q.ebuf_sz)
         EBUF_14: fill_need = FILL_14BIT;
         EBUF_6: fill_need = FILL_6BIT;
         EBUF_2: fill_need = FILL_2BIT;
         default: fill_need = FILL_2BIT;
      endcase
   end

   assign push = line_valid_i && !bypass && (q.cnt != BUF_DEPTH);
   assign pop = link_edge && !bypass && q.started && (q.cnt != 5'h00);
   // overflow: a dibit arrives with no room
   assign ovf_ev = line_valid_i && !bypass && (q.cnt == BUF_DEPTH);
   // underflow: the MAC side needs a dibit mid-frame and none is held
   assign unf_ev = link_edge && !bypass && q.started && (q.cnt == 5'h00) && line_dv_i;

   always_comb begin
      ctl_rd = 16'h0000;
      ctl_rd[RGMII_EN_BIT] = q.rgmii_en;
      ctl_rd[TX_SHIFT_BIT] = q.tx_shift;
      ctl_rd[REF_SEL_BIT] = q.ref_sel;
      ctl_rd[FIFO_NORM_BIT] = q.fifo_norm;
      ctl_rd[RMII_SEL_BIT] = q.rmii_sel;
      ctl_rd[REV10_BIT] = q.rev10;
      ctl_rd[OVF_BIT] = q.ovf;
      ctl_rd[UNF_BIT] = q.unf;
      ctl_rd[EBUF_LSB +: 2] = q.ebuf_sz;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      // pin inputs pass two flops before use
      d.ref_s1 = ref_clk_i;
      d.ref_s2 = q.ref_s1;
      d.ref_s3 = q.ref_s2;
      d.strap_s1 = ref_freq_strap_pin_i;
      d.strap_s2 = q.strap_s1;

      // catch the strap once the synchroniser has settled after reset
      if (!q.strap_done) begin
         if (q.strap_cnt == STRAP_SETTLE) begin
            d.ref_sel = q.strap_s2;
            d.strap_done = 1'b1;
         end else begin
            d.strap_cnt = q.strap_cnt + 2'h1;
         end
      end

      // bus slave: one wait state, unmapped words read zero
      d.ack = bus_req;
      d.dat = 32'h0000_0000;
      if (rd_ack) begin
         unique case (idx)
            CTL_IDX: d.dat = {16'h0000, ctl_rd};
            IRQ_ST_IDX: d.dat = {30'h0, q.irq_st};
            IRQ_MASK_IDX: d.dat = {30'h0, q.irq_mask};
            default: d.dat = 32'h0000_0000;
         endcase
      end
      // clear on read; a same-cycle event below wins
      if (rd_ack && idx == CTL_IDX) begin
         d.ovf = 1'b0;
         d.unf = 1'b0;
      end
      if (wr_ack && idx == CTL_IDX) begin
         if (wb_sel_i[1]) begin
            d.rgmii_en = wb_dat_i[RGMII_EN_BIT];
            d.tx_shift = wb_dat_i[TX_SHIFT_BIT];
         end
         if (wb_sel_i[0]) begin
            d.ref_sel = wb_dat_i[REF_SEL_BIT];
            d.fifo_norm = wb_dat_i[FIFO_NORM_BIT];
            d.rmii_sel = wb_dat_i[RMII_SEL_BIT];
            d.rev10 = wb_dat_i[REV10_BIT];
            d.ebuf_sz = wb_dat_i[EBUF_LSB +: 2];
            // flag bits are not taken from the write
         end
      end
      if (wr_ack && idx == IRQ_ST_IDX && wb_sel_i[0]) begin
         d.irq_st = q.irq_st & ~wb_dat_i[1:0];
      end
      if (wr_ack && idx == IRQ_MASK_IDX && wb_sel_i[0]) begin
         d.irq_mask = wb_dat_i[1:0];
      end

      if (ovf_ev) begin
         d.ovf = 1'b1;
         d.irq_st[IRQ_OVF_BIT] = 1'b1;
      end
      if (unf_ev) begin
         d.unf = 1'b1;
         d.irq_st[IRQ_UNF_BIT] = 1'b1;
      end
      d.irq = |(d.irq_st & q.irq_mask);

      // reduced mode only while the gigabit enable is clear
      d.rmii_mode = q.rmii_sel && !q.rgmii_en;
      // the sampled reference goes straight out while bypassed
      d.rx_clk = bypass ? q.ref_s2 : 1'b0;

      // line side fills the elasticity buffer on its own pace
      if (push) begin
         d.mem[q.wr_ptr] = line_d_i;
         d.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (line_valid_i) begin
         d.byp_d = line_d_i;
      end
      if (pop) begin
         d.rd_ptr = q.rd_ptr + 1'b1;
      end
      d.cnt = q.cnt + {4'h0, push} - {4'h0, pop};

      if (link_edge) begin
         if (bypass) begin
            // no buffering: latest dibit and the line carrier
            d.rxd = q.byp_d;
            d.crs_dv = line_dv_i;
            d.started = 1'b0;
         end else if (!q.started) begin
            d.rxd = 2'h0;
            d.crs_dv = 1'b0;
            d.tgl = 1'b0;
            // release once the tolerance margin is held
            if (line_dv_i && q.cnt >= fill_need) begin
               d.started = 1'b1;
            end
         end else if (q.cnt != 5'h00) begin
            d.rxd = q.mem[q.rd_ptr];
            if (line_dv_i || q.rev10) begin
               d.crs_dv = 1'b1;
            end else begin
               // carrier lost: alternate while the rest drains
               d.crs_dv = q.tgl;
               d.tgl = !q.tgl;
            end
         end else if (line_dv_i) begin
            // starved mid-frame: hold the carrier, send idle data
            d.rxd = 2'h0;
         end else begin
            d.started = 1'b0;
            d.rxd = 2'h0;
            d.crs_dv = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.fifo_norm <= FIFO_NORM_RST;
         q.ebuf_sz <= EBUF_RST;
      end else begin
         q <= d;
      end
   end

   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign rxd_o = q.rxd;
   assign crs_dv_o = q.crs_dv;
   assign rx_clk_o = q.rx_clk;
   assign tx_clk_shift_o = q.tx_shift;
   assign ref_sel_o = q.ref_sel;
   assign rmii_mode_o = q.rmii_mode;
   assign irq_o = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   tx_shift_write_a: assert property (
      wr_ack && idx == CTL_IDX && wb_sel_i[1] |=> tx_clk_shift_o == $past(wb_dat_i[TX_SHIFT_BIT])
   ) else $error("tx shift did not follow the write");

   strap_capture_a: assert property (
      $rose(q.strap_done) |-> ref_sel_o == $past(q.strap_s2)
   ) else $error("strap level not captured");

   strap_time_a: assert property (
      $rose(rst_n_i) |-> ##3 q.strap_done
   ) else $error("strap capture late");

   bypass_clock_a: assert property (
      bypass && $past(bypass) |-> rx_clk_o == $past(q.ref_s2)
   ) else $error("receive clock not passed through in bypass");

   mode_follow_a: assert property (
      ##1 rmii_mode_o == $past(q.rmii_sel && !q.rgmii_en)
   ) else $error("interface mode wrong");

   rev10_hold_a: assert property (
      pop && q.rev10 |=> crs_dv_o
   ) else $error("carrier dropped while draining in rev 1.0");

   rev12_toggle_a: assert property (
      pop && !q.rev10 && !line_dv_i |=> crs_dv_o == $past(q.tgl) ##0 q.tgl != $past(q.tgl)
   ) else $error("carrier did not toggle while draining");

   ovf_flag_a: assert property (
      ovf_ev |=> q.ovf && q.irq_st[IRQ_OVF_BIT]
   ) else $error("overflow not flagged");

   unf_flag_a: assert property (
      unf_ev |=> q.unf && q.irq_st[IRQ_UNF_BIT]
   ) else $error("underflow not flagged");

   flag_clear_a: assert property (
      bus_req && idx == CTL_IDX && !ovf_ev && !unf_ev |=> (q.ovf == ($past(q.ovf) && $past(wb_we_i)))
   ) else $error("overflow flag changed by write or kept after read");

   fill_start_a: assert property (
      $rose(q.started) |-> $past(q.cnt) >= $past(fill_need)
   ) else $error("released before the tolerance margin filled");

   ebuf_reset_a: assert property (
      $rose(rst_n_i) |-> q.ebuf_sz == EBUF_RST && q.fifo_norm
   ) else $error("size field or fifo bit reset wrong");

   irq_level_a: assert property (
      ##1 irq_o == |($past(d.irq_st) & $past(q.irq_mask))
   ) else $error("interrupt output wrong");

   ack_pulse_a: assert property (
      wb_ack_o |=> !wb_ack_o
   ) else $error("ack held longer than one cycle");

   read_zero_a: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000
   ) else $error("read data not zero outside the ack cycle");

   ref_write_a: assert property (
      wr_ack && idx == CTL_IDX && wb_sel_i[0] && q.strap_done
         |=> ref_sel_o == $past(wb_dat_i[REF_SEL_BIT])
   ) else $error("reference select did not follow the write");

   unf_write_a: assert property (
      wr_ack && idx == CTL_IDX && !unf_ev |=> q.unf == $past(q.unf)
   ) else $error("underflow flag changed by a write");

   bypass_frozen_a: assert property (
      bypass |=> q.cnt == $past(q.cnt)
   ) else $error("buffer level moved while bypassed");

   rxd_stands_a: assert property (
      !link_edge |=> $stable(rxd_o) && $stable(crs_dv_o)
   ) else $error("receive outputs changed between reference edges");

   size_write_a: assert property (
      wr_ack && idx == CTL_IDX && wb_sel_i[0] |=> q.ebuf_sz == $past(wb_dat_i[EBUF_LSB +: 2])
   ) else $error("size field did not follow the write");

   frame_drained_c: cover property ($fell(q.started) ##1 !crs_dv_o);
   overflow_seen_c: cover property (ovf_ev);
   bypass_frame_c: cover property (bypass && crs_dv_o);
   rev12_tail_c: cover property (pop && !q.rev10 && !line_dv_i);
endmodule : rmii_rx_path_config
`default_nettype wire

// file: bench/mac_rx_model.sv
// receiving MAC: makes the free-running reference clock and collects dibits
// assumes the block's outputs are settled well before each reference rising edge
`timescale 1ns/10ps
`default_nettype none
module mac_rx_model (
   output logic ref_clk_o,
   input wire logic [1:0] rxd_i,
   input wire logic crs_dv_i
);
   logic [1:0] got[$];
   int falls;
   logic crs_q;
   // reference clock supplied by the far side, scaled down for the bench
   initial begin
      ref_clk_o = 1'b0;
      falls = 0;
      crs_q = 1'b0;
      #37;
      forever #100 ref_clk_o = ~ref_clk_o;
   end
   // data taken only while carrier/data valid is high
   always @(posedge ref_clk_o) begin
      if (crs_dv_i === 1'b1) got.push_back(rxd_i);
      if (crs_q === 1'b1 && crs_dv_i === 1'b0) falls++;
      crs_q = crs_dv_i;
   end
endmodule : mac_rx_model
`default_nettype wire

// file: bench/rmii_rx_path_config_tb_top.sv
// self-checking bench: register bus, interrupts, receive stream and bypass
// assumes the partner model supplies the reference clock
`timescale 1ns/10ps
`default_nettype none
module rmii_rx_path_config_tb_top;
   logic clk_i, rst_n, cyc, stb, we, strap, line_dv, line_valid, ref_clk;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q, rnd;
   logic [1:0] line_d, rxd;
   logic ack, crs_dv, rx_clk, tx_sh, ref_sel, rmii, irq;
   logic [1:0] exp_d[$];
   int fail_count, check_count, seed, i, hi, lo;
   rmii_rx_path_config rmii_rx_path_config_inst (.clk_i(clk_i), .rst_n_i(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ref_clk_i(ref_clk),
      .ref_freq_strap_pin_i(strap), .line_dv_i(line_dv), .line_valid_i(line_valid),
      .line_d_i(line_d), .rxd_o(rxd), .crs_dv_o(crs_dv), .rx_clk_o(rx_clk),
      .tx_clk_shift_o(tx_sh), .ref_sel_o(ref_sel), .rmii_mode_o(rmii), .irq_o(irq));
   mac_rx_model mac_rx_model_inst (.ref_clk_o(ref_clk), .rxd_i(rxd), .crs_dv_i(crs_dv));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task final_report;
      if (fail_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // classic cycle: request held until ack is sampled, then one idle cycle
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // a hang here is ended by the watchdog
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task push(input int k, input logic keep);
      logic [1:0] v;
      for (int j = 0; j < k; j++) begin
         @(posedge clk_i);
         v = 2'($random(seed));
         line_d <= v;
         line_valid <= 1'b1;
         if (keep) exp_d.push_back(v);
      end
      @(posedge clk_i);
      line_valid <= 1'b0;
   endtask : push
   function automatic logic [31:0] ctl_exp(input logic [31:0] w);
      return w & 32'h0000_03F3;
   endfunction : ctl_exp
   // one frame of four dibits, carrier dropped once output has begun
   task frame(input logic rev10);
      bus(1'b1, 8'h5C, 32'h0000_00E1 | (32'(rev10) << 4));
      exp_d.delete();
      mac_rx_model_inst.got.delete();
      mac_rx_model_inst.falls = 0;
      line_dv <= 1'b1;
      push(4, 1'b1);
      while (crs_dv !== 1'b1) @(posedge clk_i);
      line_dv <= 1'b0;
      repeat (200) @(posedge clk_i);
      if (rev10) begin
         chk(mac_rx_model_inst.got.size(), 4);
         for (int j = 0; j < 4; j++) chk(mac_rx_model_inst.got[j], exp_d[j]);
         chk(mac_rx_model_inst.falls, 1);
      end else begin
         chk(mac_rx_model_inst.falls > 1, 1);
         chk(mac_rx_model_inst.got[0], exp_d[0]);
      end
   endtask : frame
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      #300000;
      fail_count++;
      final_report();
   end
   initial begin
      {rst_n, cyc, stb, we, line_dv, line_valid} = '0;
      strap = 1'b1;
      adr = 8'h00;
      sel = 4'h3;
      wdat = 32'h0;
      line_d = 2'h0;
      seed = 32'h96F3;
      fail_count = 0;
      check_count = 0;
      repeat (5) @(posedge clk_i);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      bus(1'b0, 8'h5C, 32'h0);
      chk(q, 32'h0000_00C1);
      chk({tx_sh, ref_sel, rmii, irq, rx_clk}, 5'h08);
      for (i = 0; i < 8; i++) begin
         rnd = $random(seed);
         bus(1'b1, 8'h5C, rnd);
         bus(1'b0, 8'h5C, 32'h0);
         chk(q, ctl_exp(rnd));
         chk({tx_sh, ref_sel}, {rnd[8], rnd[7]});
         chk(rmii, rnd[5] & ~rnd[9]);
      end
      bus(1'b0, 8'h7C, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h64, 32'h3);
      frame(1'b1);
      frame(1'b0);
      // underflow: carrier held with a single dibit
      line_dv <= 1'b1;
      push(1, 1'b0);
      repeat (40) @(posedge clk_i);
      line_dv <= 1'b0;
      bus(1'b0, 8'h5C, 32'h0);
      chk(q[2], 1'b1);
      bus(1'b0, 8'h5C, 32'h0);
      chk(q[2], 1'b0);
      bus(1'b0, 8'h60, 32'h0);
      chk(q, 32'h1);
      chk(irq, 1'b1);
      bus(1'b1, 8'h60, 32'h1);
      chk(irq, 1'b0);
      bus(1'b1, 8'h64, 32'h0);
      // bypass: reference clock forwarded and carrier passed through
      bus(1'b1, 8'h5C, 32'h0000_00A1);
      line_dv <= 1'b1;
      push(1, 1'b1);
      hi = 0;
      lo = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (rx_clk === 1'b1) hi++;
         if (rx_clk === 1'b0) lo++;
      end
      chk(hi > 0 && lo > 0, 1);
      chk(crs_dv, 1'b1);
      chk(rxd, exp_d[$]);
      line_dv <= 1'b0;
      bus(1'b1, 8'h5C, 32'h0000_00E1);
      // overflow: seventeen pushes with no carrier, interrupt masked first
      push(17, 1'b0);
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b0);
      bus(1'b1, 8'h64, 32'h2);
      // the output follows a mask write one cycle after the ack
      @(posedge clk_i);
      chk(irq, 1'b1);
      bus(1'b0, 8'h5C, 32'h0);
      chk(q[3], 1'b1);
      bus(1'b0, 8'h5C, 32'h0);
      chk(q[3], 1'b0);
      bus(1'b1, 8'h60, 32'h2);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      final_report();
   end
endmodule : rmii_rx_path_config_tb_top
`default_nettype wire
